/* File: ccrc_top.sv */
// connector resistance classifier: sideband accessory classes and moisture measurement control
// assumes the serial decoder presents byte writes and reads on the register port, and an analog
// engine outside runs each measurement and pulses done with its outcome
`timescale 1ns/1ps
`default_nettype none
module ccrc_top
	import ccrc_pkg::*;
#(
	parameter logic [31:0] MOIST_PERIOD_CYCLES = CCRC_MOIST_PERIOD_CYC
)(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic debug_acc_sink,
	input wire logic unattached,
	input wire logic sideband_manual_request,
	output logic sb_meas_start,
	input wire logic sb_meas_done,
	input wire logic [1:0] sbu1_ipu,
	input wire logic [7:0] sbu1_adc,
	input wire logic sbu1_abort,
	input wire logic sbu1_ground,
	input wire logic sbu1_open,
	input wire logic [1:0] sbu2_ipu,
	input wire logic [7:0] sbu2_adc,
	input wire logic sbu2_abort,
	input wire logic sbu2_ground,
	input wire logic sbu2_open,
	output logic [7:0] sbu1_final_adc,
	output logic [7:0] sbu2_final_adc,
	output logic [4:0] sbu1_acc_match,
	output logic [4:0] sbu2_acc_match,
	output logic moist_meas_start,
	input wire logic moist_meas_done,
	output logic [5:0] moist_pullup_en,
	output logic [6:0] moist_pulldown_en,
	output logic [14:0] moisture_resistance_threshold
);
	// ==========================================================
	// registers
	logic [7:0] acc_vmax [CCRC_NUM_ACC];
	logic [7:0] acc_vmin [CCRC_NUM_ACC];
	logic [1:0] acc_code [CCRC_NUM_ACC];
	logic [2:0] sideband_measure_control;
	logic [7:0] moisture_voltage_threshold;
	logic [4:0] moisture_control;
	logic [5:0] moisture_pullup_select;
	logic [6:0] moisture_pulldown_select;
	logic moist_clear_manual;

	genvar gi;
	generate
		for (gi = 0; gi < CCRC_NUM_ACC; gi++)
		begin : g_acc_regs
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					acc_vmax[gi] <= CCRC_ACC_VMAX_RST[gi];
					acc_vmin[gi] <= CCRC_ACC_VMIN_RST[gi];
					acc_code[gi] <= CCRC_ACC_CODE_RST[gi];
				end
				else if (reg_wr)
				begin
					if (reg_addr == CCRC_ACC_VMAX_OFS[gi])
						acc_vmax[gi] <= reg_wdata;
					if (reg_addr == CCRC_ACC_VMIN_OFS[gi])
						acc_vmin[gi] <= reg_wdata;
					if (reg_addr == CCRC_ACC_CODE_OFS[gi])
						acc_code[gi] <= reg_wdata[1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sideband_measure_control <= CCRC_SB_CTRL_RST;
			moisture_voltage_threshold <= CCRC_MOIST_VTH_RST;
			moisture_pullup_select <= CCRC_MOIST_PU_RST;
			moisture_pulldown_select <= CCRC_MOIST_PD_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == CCRC_SB_CTRL_OFS)
				sideband_measure_control <= reg_wdata[2:0];
			if (reg_addr == CCRC_MOIST_VTH_OFS)
				moisture_voltage_threshold <= reg_wdata;
			if (reg_addr == CCRC_MOIST_PU_OFS)
				moisture_pullup_select <= reg_wdata[5:0];
			if (reg_addr == CCRC_MOIST_PD_OFS)
				moisture_pulldown_select <= reg_wdata[6:0];
		end
	end

	// a software write in the same cycle as the hardware clear wins, so a fresh request is kept
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			moisture_control <= CCRC_MOIST_CTRL_RST;
		else if (reg_wr && reg_addr == CCRC_MOIST_CTRL_OFS)
			moisture_control <= reg_wdata[4:0];
		else if (moist_clear_manual)
			moisture_control[CCRC_MC_MAN_BIT] <= 1'b0;
	end

	logic [7:0] next_rdata;
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			CCRC_SB_CTRL_OFS: next_rdata = {5'h00, sideband_measure_control};
			CCRC_MOIST_VTH_OFS: next_rdata = moisture_voltage_threshold;
			CCRC_MOIST_CTRL_OFS: next_rdata = {3'h0, moisture_control};
			CCRC_MOIST_PU_OFS: next_rdata = {2'h0, moisture_pullup_select};
			CCRC_MOIST_PD_OFS: next_rdata = {1'b0, moisture_pulldown_select};
			default: next_rdata = 8'h00;
		endcase
		for (int i = 0; i < CCRC_NUM_ACC; i++)
		begin
			if (reg_addr == CCRC_ACC_VMAX_OFS[i])
				next_rdata = acc_vmax[i];
			if (reg_addr == CCRC_ACC_VMIN_OFS[i])
				next_rdata = acc_vmin[i];
			if (reg_addr == CCRC_ACC_CODE_OFS[i])
				next_rdata = {6'h00, acc_code[i]};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// ==========================================================
	// sideband measurement launch
	wire logic sb_man_en = sideband_measure_control[CCRC_SB_MAN_BIT];
	wire logic sb_one_en = sideband_measure_control[CCRC_SB_ONE_BIT];
	wire logic sb_cont_en = sideband_measure_control[CCRC_SB_CONT_BIT];
	ccrc_state_e sb_state;
	logic sb_one_taken;
	logic sb_auto_go;
	logic sb_man_go;
	logic sb_go;

	assign sb_auto_go = debug_acc_sink && (sb_cont_en || (sb_one_en && !sb_one_taken));
	assign sb_man_go = sb_man_en && sideband_manual_request;
	assign sb_go = (sb_state == CCRC_IDLE) && (sb_auto_go || sb_man_go);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sb_state <= CCRC_IDLE;
			sb_meas_start <= 1'b0;
		end
		else
		begin
			sb_meas_start <= sb_go;
			case (sb_state)
				CCRC_IDLE: if (sb_go) sb_state <= CCRC_BUSY;
				CCRC_BUSY: if (sb_meas_done) sb_state <= CCRC_IDLE;
				default: sb_state <= CCRC_IDLE;
			endcase
		end
	end

	// one shot rearms when the sink mode ends or software rewrites the control register
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			sb_one_taken <= 1'b0;
		else if (!debug_acc_sink || (reg_wr && reg_addr == CCRC_SB_CTRL_OFS))
			sb_one_taken <= 1'b0;
		else if (sb_go && sb_one_en && !sb_cont_en && !sb_man_go)
			sb_one_taken <= 1'b1;
	end

	// ==========================================================
	// sideband results and class matching
	logic [1:0] pin_ipu [2];
	logic [7:0] pin_adc [2];
	logic [1:0] pin_zero;
	logic [1:0] pin_open;
	logic [7:0] final_adc [2];
	logic [4:0] acc_match [2];
	assign pin_ipu[0] = sbu1_ipu;
	assign pin_ipu[1] = sbu2_ipu;
	assign pin_adc[0] = sbu1_adc;
	assign pin_adc[1] = sbu2_adc;
	assign pin_zero = {sbu2_abort || sbu2_ground, sbu1_abort || sbu1_ground};
	assign pin_open = {sbu2_open, sbu1_open};

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			logic [7:0] next_final;
			assign next_final = pin_zero[gi] ? CCRC_ADC_LOW : (pin_open[gi] ? CCRC_ADC_HIGH : pin_adc[gi]);
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
					final_adc[gi] <= CCRC_ADC_LOW;
				else if (sb_meas_done)
					final_adc[gi] <= next_final;
			end
			for (genvar ci = 0; ci < CCRC_NUM_ACC; ci++)
			begin : g_class
				always_ff @(posedge sys_clk or negedge rstn)
				begin
					if (!rstn)
						acc_match[gi][ci] <= 1'b0;
					else if (sb_meas_done)
						acc_match[gi][ci] <= (pin_ipu[gi] == acc_code[ci]) && (next_final >= acc_vmin[ci])
							&& (next_final <= acc_vmax[ci]);
				end
			end
		end
	endgenerate
	assign sbu1_final_adc = final_adc[0];
	assign sbu2_final_adc = final_adc[1];
	assign sbu1_acc_match = acc_match[0];
	assign sbu2_acc_match = acc_match[1];

	// ==========================================================
	// moisture scheduling
	wire logic mo_auto = moisture_control[CCRC_MC_AUTO_BIT];
	wire logic mo_per_en = moisture_control[CCRC_MC_PER_BIT];
	wire logic mo_man_en = moisture_control[CCRC_MC_MAN_BIT];
	wire logic [1:0] mo_ipu = moisture_control[CCRC_MC_IPU_LSB +: 2];
	ccrc_state_e mo_state;
	logic [31:0] mo_timer;
	logic mo_due;
	logic mo_by_manual;
	logic mo_use_cc2;
	logic mo_go;

	// the timer only runs while unattached, so an attach skips the pending period entirely
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mo_timer <= 32'h0;
			mo_due <= 1'b0;
		end
		else if (!unattached || !mo_per_en)
		begin
			mo_timer <= 32'h0;
			mo_due <= 1'b0;
		end
		else if (mo_timer >= MOIST_PERIOD_CYCLES - 32'h1)
		begin
			mo_timer <= 32'h0;
			mo_due <= 1'b1;
		end
		else
		begin
			mo_timer <= mo_timer + 32'h1;
			if (mo_go)
				mo_due <= 1'b0;
		end
	end

	assign mo_go = (mo_state == CCRC_IDLE) && unattached && (mo_due || mo_man_en);
	assign moist_clear_manual = (mo_state == CCRC_BUSY) && moist_meas_done && mo_by_manual;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mo_state <= CCRC_IDLE;
			moist_meas_start <= 1'b0;
			mo_by_manual <= 1'b0;
			mo_use_cc2 <= 1'b0;
		end
		else
		begin
			moist_meas_start <= mo_go;
			case (mo_state)
				CCRC_IDLE:
					if (mo_go)
					begin
						mo_state <= CCRC_BUSY;
						mo_by_manual <= mo_man_en;
					end
				CCRC_BUSY:
					if (moist_meas_done)
					begin
						mo_state <= CCRC_IDLE;
						mo_use_cc2 <= !mo_use_cc2;
					end
				default: mo_state <= CCRC_IDLE;
			endcase
		end
	end

	// switch selection, refreshed every cycle from the current configuration
	logic [5:0] next_pu;
	logic [6:0] next_pd;
	always_comb
	begin
		next_pu = moisture_pullup_select;
		next_pd = moisture_pulldown_select;
		if (mo_auto)
		begin
			next_pu = '0;
			next_pu[mo_use_cc2 ? CCRC_PIN_CC2 : CCRC_PIN_CC1] = 1'b1;
			next_pd = ~{1'b0, next_pu};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			moist_pullup_en <= '0;
			moist_pulldown_en <= '0;
			moisture_resistance_threshold <= '0;
		end
		else
		begin
			moist_pullup_en <= next_pu;
			moist_pulldown_en <= next_pd;
			// both factors widened first so the product is not cut to eight bits
			moisture_resistance_threshold <= 15'(CCRC_IPU_UA[mo_ipu]) * 15'(moisture_voltage_threshold);
		end
	end

	// ==========================================================
	// checks
	sequence s_sb_idle_cont;
		sb_state == CCRC_IDLE && debug_acc_sink && sb_cont_en;
	endsequence
	sequence s_mo_pending_attached;
		mo_man_en && !unattached && !(reg_wr && reg_addr == CCRC_MOIST_CTRL_OFS);
	endsequence

	chk_cont_launch: assert property (@(posedge sys_clk) disable iff (!rstn) s_sb_idle_cont |=> sb_meas_start)
		else $error("continuous sideband measurement not launched");
	chk_sb_mode_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(sb_meas_start) && !$past(sb_man_go) |-> $past(debug_acc_sink))
		else $error("sideband measurement launched outside debug sink mode");
	chk_manual_block: assert property (@(posedge sys_clk) disable iff (!rstn)
		sideband_manual_request && !sb_man_en && !debug_acc_sink |=> !sb_meas_start)
		else $error("manual sideband measurement not blocked");
	chk_open_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
		sb_meas_done && sbu1_open && !sbu1_abort && !sbu1_ground |=> sbu1_final_adc == 8'hFF)
		else $error("open result not reported as full scale");
	chk_class_window: assert property (@(posedge sys_clk) disable iff (!rstn)
		sb_meas_done |=> sbu2_acc_match[0] == ($past(sbu2_ipu) == $past(acc_code[0])
		&& sbu2_final_adc >= $past(acc_vmin[0]) && sbu2_final_adc <= $past(acc_vmax[0])))
		else $error("class one flag disagrees with window");
	chk_moist_attached: assert property (@(posedge sys_clk) disable iff (!rstn)
		moist_meas_start |-> $past(unattached))
		else $error("moisture measurement launched while attached");
	chk_manual_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		moist_clear_manual && !(reg_wr && reg_addr == CCRC_MOIST_CTRL_OFS) |=> !mo_man_en)
		else $error("moisture manual bit not self-cleared");
	chk_manual_pending: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_mo_pending_attached |=> mo_man_en && !moist_meas_start)
		else $error("moisture manual request lost while attached");
	chk_auto_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
		mo_auto ##1 mo_auto |-> $onehot(moist_pullup_en) && moist_pullup_en[5:2] == 4'h0
		&& moist_pulldown_en == ~{1'b0, moist_pullup_en})
		else $error("automatic moisture pin set wrong");
	chk_manual_pins: assert property (@(posedge sys_clk) disable iff (!rstn)
		!mo_auto |=> moist_pullup_en == $past(moisture_pullup_select)
		&& moist_pulldown_en == $past(moisture_pulldown_select))
		else $error("manual moisture pins differ from selects");
	chk_threshold: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 1'b1 |-> moisture_resistance_threshold
		== 15'($past(CCRC_IPU_UA[mo_ipu])) * 15'($past(moisture_voltage_threshold)))
		else $error("moisture threshold product wrong");
endmodule : ccrc_top
`default_nettype wire

/* File: ccrc_pkg.sv */
// constants shared by the connector resistance classifier
// assumes one 200 MHz clock and an internal byte-wide register port behind the serial interface
package ccrc_pkg;
	localparam int CCRC_NUM_ACC = 5;
	localparam int CCRC_NUM_PU = 6;
	localparam int CCRC_NUM_PD = 7;
	localparam longint CCRC_CLK_HZ = 200000000;
	localparam longint CCRC_MOIST_PERIOD_S = 10;
	localparam logic [31:0] CCRC_MOIST_PERIOD_CYC = 32'(CCRC_MOIST_PERIOD_S * CCRC_CLK_HZ);
	// ==========================================================
	// register offsets
	localparam logic [7:0] CCRC_SB_CTRL_OFS = 8'h30;
	localparam logic [7:0] CCRC_MOIST_VTH_OFS = 8'h50;
	localparam logic [7:0] CCRC_MOIST_CTRL_OFS = 8'h51;
	localparam logic [7:0] CCRC_MOIST_PU_OFS = 8'h52;
	localparam logic [7:0] CCRC_MOIST_PD_OFS = 8'h53;
	localparam logic [7:0] CCRC_ACC_VMAX_OFS [CCRC_NUM_ACC] = '{8'h31, 8'h34, 8'h37, 8'h3B, 8'h3D};
	localparam logic [7:0] CCRC_ACC_VMIN_OFS [CCRC_NUM_ACC] = '{8'h32, 8'h35, 8'h38, 8'h3A, 8'h3E};
	localparam logic [7:0] CCRC_ACC_CODE_OFS [CCRC_NUM_ACC] = '{8'h33, 8'h36, 8'h39, 8'h3C, 8'h3F};
	// ==========================================================
	// reset values
	localparam logic [7:0] CCRC_ACC_VMAX_RST [CCRC_NUM_ACC] = '{8'hAE, 8'h74, 8'hD9, 8'h00, 8'h00};
	localparam logic [7:0] CCRC_ACC_VMIN_RST [CCRC_NUM_ACC] = '{8'h99, 8'h66, 8'hBF, 8'h00, 8'h00};
	localparam logic [1:0] CCRC_ACC_CODE_RST [CCRC_NUM_ACC] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
	localparam logic [2:0] CCRC_SB_CTRL_RST = 3'h4;
	localparam logic [7:0] CCRC_MOIST_VTH_RST = 8'h66;
	localparam logic [4:0] CCRC_MOIST_CTRL_RST = 5'h1A;
	localparam logic [5:0] CCRC_MOIST_PU_RST = 6'h00;
	localparam logic [6:0] CCRC_MOIST_PD_RST = 7'h00;
	// ==========================================================
	// field positions
	localparam int CCRC_SB_MAN_BIT = 0;
	localparam int CCRC_SB_ONE_BIT = 1;
	localparam int CCRC_SB_CONT_BIT = 2;
	localparam int CCRC_MC_IPU_LSB = 0;
	localparam int CCRC_MC_MAN_BIT = 2;
	localparam int CCRC_MC_PER_BIT = 3;
	localparam int CCRC_MC_AUTO_BIT = 4;
	localparam int CCRC_PIN_CC1 = 0;
	localparam int CCRC_PIN_CC2 = 1;
	// ==========================================================
	// pull-up currents in microamps and adc clamp values
	localparam logic [7:0] CCRC_IPU_UA [4] = '{8'h02, 8'h08, 8'h20, 8'h80};
	localparam logic [7:0] CCRC_ADC_LOW = 8'h00;
	localparam logic [7:0] CCRC_ADC_HIGH = 8'hFF;
	typedef enum logic {CCRC_IDLE, CCRC_BUSY} ccrc_state_e;
endpackage : ccrc_pkg

/* File: ccrc_engine_model.sv */
// behavioural measurement engine standing on the connector side of the classifier
// assumes launches are one-cycle pulses; it answers lat + 1 cycles after sampling a launch, changing only on the falling edge
`timescale 1ns/1ps
`default_nettype none
module ccrc_engine_model
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic sb_meas_start,
	input wire logic moist_meas_start,
	input wire logic [3:0] lat,
	input wire logic [11:0] pay1,
	input wire logic [11:0] pay2,
	output logic sb_meas_done,
	output logic moist_meas_done,
	output logic [12:0] sbu1_bus,
	output logic [12:0] sbu2_bus
);
	int sb_cnt;
	int mo_cnt;
	// ==========
	// pin result: payload is {outcome, ipu, adc}, outcome 1 abort, 2 ground, 3 open
	// outside done the lines carry the inverse so a stale value is never mistaken for a result
	function automatic logic [12:0] pin(input logic [11:0] p, input logic v);
		logic [1:0] ipu;
		ipu = (p[11:10] == 2'h2) ? 2'h3 : ((p[11:10] == 2'h0) ? p[9:8] : 2'h0);
		return v ? {ipu, p[7:0], p[11:10] == 2'h1, p[11:10] == 2'h2, p[11:10] == 2'h3} : ~{ipu, p[7:0], 3'h0};
	endfunction : pin
	assign sbu1_bus = pin(pay1, sb_meas_done);
	assign sbu2_bus = pin(pay2, sb_meas_done);
	always @(negedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sb_cnt <= -1;
			mo_cnt <= -1;
			sb_meas_done <= 1'b0;
			moist_meas_done <= 1'b0;
		end
		else
		begin
			sb_meas_done <= (sb_cnt == 0);
			moist_meas_done <= (mo_cnt == 0);
			sb_cnt <= sb_meas_start ? int'(lat) : ((sb_cnt >= 0) ? sb_cnt - 1 : -1);
			mo_cnt <= moist_meas_start ? int'(lat) : ((mo_cnt >= 0) ? mo_cnt - 1 : -1);
		end
	end
endmodule : ccrc_engine_model
`default_nettype wire

/* File: ccrc_top_tb.sv */
// self-checking bench for the connector resistance classifier
// assumes ccrc_engine_model as the measurement engine and a moisture period shortened to 100 cycles
`timescale 1ns/1ps
`default_nettype none
module ccrc_top_tb
	import ccrc_pkg::*;
;
	localparam int PER = 100;
	logic sys_clk, rstn, reg_wr, reg_rd, debug_acc_sink, unattached, sideband_manual_request;
	logic sb_meas_start, sb_meas_done, moist_meas_start, moist_meas_done;
	logic sbu1_abort, sbu1_ground, sbu1_open, sbu2_abort, sbu2_ground, sbu2_open;
	logic [1:0] sbu1_ipu, sbu2_ipu;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, sbu1_adc, sbu2_adc, sbu1_final_adc, sbu2_final_adc;
	logic [4:0] sbu1_acc_match, sbu2_acc_match;
	logic [5:0] moist_pullup_en;
	logic [6:0] moist_pulldown_en;
	logic [14:0] moisture_resistance_threshold;
	logic [3:0] lat;
	logic [11:0] pay1, pay2;
	logic [7:0] mreg [256];
	logic [7:0] v1, v2, r;
	logic [12:0] e1, e2;
	logic [31:0] lfsr;
	int error_cnt, total_checks, sb_starts, mo_starts, base;
	bit cc2_turn;
	ccrc_top #(.MOIST_PERIOD_CYCLES(32'd100)) ccrc_top_inst (.sys_clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .debug_acc_sink, .unattached, .sideband_manual_request, .sb_meas_start,
		.sb_meas_done, .sbu1_ipu, .sbu1_adc, .sbu1_abort, .sbu1_ground, .sbu1_open, .sbu2_ipu, .sbu2_adc,
		.sbu2_abort, .sbu2_ground, .sbu2_open, .sbu1_final_adc, .sbu2_final_adc, .sbu1_acc_match,
		.sbu2_acc_match, .moist_meas_start, .moist_meas_done, .moist_pullup_en, .moist_pulldown_en,
		.moisture_resistance_threshold);
	ccrc_engine_model ccrc_engine_model_inst (.sys_clk, .rstn, .sb_meas_start, .moist_meas_start, .lat, .pay1,
		.pay2, .sb_meas_done, .moist_meas_done,
		.sbu1_bus({sbu1_ipu, sbu1_adc, sbu1_abort, sbu1_ground, sbu1_open}),
		.sbu2_bus({sbu2_ipu, sbu2_adc, sbu2_abort, sbu2_ground, sbu2_open}));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ==========
	// helpers
	function automatic logic [7:0] rnd();
		repeat (8) lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'hD0000001 : 32'h00000000);
		return lfsr[7:0];
	endfunction : rnd
	function automatic logic [7:0] msk(input logic [7:0] a);
		if (a == CCRC_SB_CTRL_OFS) return 8'h07;
		if (a == CCRC_MOIST_CTRL_OFS) return 8'h1F;
		if (a == CCRC_MOIST_PU_OFS) return 8'h3F;
		if (a == CCRC_MOIST_PD_OFS) return 8'h7F;
		if (a == CCRC_MOIST_VTH_OFS) return 8'hFF;
		if (a > 8'h30 && a < 8'h40) return (a % 8'h03 == 8'h00) ? 8'h03 : 8'hFF;
		return 8'h00;
	endfunction : msk
	// expected {matches, final adc} of one pin against every class
	function automatic logic [12:0] sb_exp(input logic [1:0] ipu, input logic [7:0] adc, input logic ab, gr, op);
		logic [7:0] f;
		logic [4:0] m;
		f = (ab | gr) ? CCRC_ADC_LOW : (op ? CCRC_ADC_HIGH : adc);
		for (int k = 0; k < CCRC_NUM_ACC; k++)
			m[k] = ipu == mreg[CCRC_ACC_CODE_OFS[k]][1:0] && f >= mreg[CCRC_ACC_VMIN_OFS[k]] && f <= mreg[CCRC_ACC_VMAX_OFS[k]];
		return {m, f};
	endfunction : sb_exp
	// boundary-heavy adc around a random class window
	function automatic logic [11:0] mk_pay();
		logic [7:0] q, a;
		int k;
		q = rnd();
		k = int'(q % 8'h05);
		a = rnd();
		case (q[7:5])
			3'h0: a = mreg[CCRC_ACC_VMIN_OFS[k]];
			3'h1: a = mreg[CCRC_ACC_VMAX_OFS[k]];
			3'h2: a = mreg[CCRC_ACC_VMIN_OFS[k]] - 8'h01;
			3'h3: a = mreg[CCRC_ACC_VMAX_OFS[k]] + 8'h01;
			default: ;
		endcase
		return {(q[4:3] == 2'h3) ? q[2:1] : 2'h0, q[0] ? mreg[CCRC_ACC_CODE_OFS[k]][1:0] : q[2:1], a};
	endfunction : mk_pay
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chk_cnt(input int got, input int exp, input string what);
		total_checks++;
		if (got != exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s count %0d exp %0d", $time, what, got, exp);
		end
	endtask : chk_cnt
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic wait_until(input bit mo, input int want, input int n);
		for (int i = 0; i < n; i++)
		begin
			if ((mo ? mo_starts : sb_starts) >= want) return;
			@(negedge sys_clk);
		end
		error_cnt++;
		$display("CHECK FAILED t=%0t launch timeout", $time);
		wrap_up();
	endtask : wait_until
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		if (msk(a) != 8'h00) mreg[a] = d & msk(a);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk(reg_rdata, mreg[a], "register read");
	endtask : rd
	task automatic chk_moist;
		logic [7:0] c;
		logic [5:0] pu;
		logic [6:0] pd;
		repeat (3) @(negedge sys_clk);
		c = mreg[CCRC_MOIST_CTRL_OFS];
		pu = c[CCRC_MC_AUTO_BIT] ? (cc2_turn ? 6'h02 : 6'h01) : mreg[CCRC_MOIST_PU_OFS][5:0];
		pd = c[CCRC_MC_AUTO_BIT] ? 7'h7F & ~{1'b0, pu} : mreg[CCRC_MOIST_PD_OFS][6:0];
		chk(moist_pullup_en, pu, "pullup");
		chk(moist_pulldown_en, pd, "pulldown");
		chk(moisture_resistance_threshold, 32'(CCRC_IPU_UA[c[1:0]]) * 32'(mreg[CCRC_MOIST_VTH_OFS]), "thr");
	endtask : chk_moist
	// ==========
	// monitors: launch counts and the result of every completed sideband measurement
	always @(posedge sys_clk)
	begin
		if (rstn === 1'b1 && sb_meas_start === 1'b1) sb_starts++;
		if (rstn === 1'b1 && moist_meas_start === 1'b1) mo_starts++;
		if (rstn === 1'b1 && moist_meas_done === 1'b1)
		begin
			if (mreg[CCRC_MOIST_CTRL_OFS][CCRC_MC_AUTO_BIT]) cc2_turn = ~cc2_turn;
			mreg[CCRC_MOIST_CTRL_OFS][CCRC_MC_MAN_BIT] = 1'b0;
		end
		if (rstn === 1'b1 && sb_meas_done === 1'b1)
		begin
			e1 = sb_exp(sbu1_ipu, sbu1_adc, sbu1_abort, sbu1_ground, sbu1_open);
			e2 = sb_exp(sbu2_ipu, sbu2_adc, sbu2_abort, sbu2_ground, sbu2_open);
			@(negedge sys_clk);
			chk({sbu1_acc_match, sbu1_final_adc}, e1, "sbu1 result");
			chk({sbu2_acc_match, sbu2_final_adc}, e2, "sbu2 result");
		end
	end
	// ==========
	// main sequence
	initial
	begin
		{rstn, reg_wr, reg_rd, debug_acc_sink, unattached, sideband_manual_request} = 6'h00;
		{reg_addr, reg_wdata, pay1, pay2, lat} = 44'h3;
		lfsr = 32'd7193;
		foreach (mreg[i]) mreg[i] = 8'h00;
		for (int k = 0; k < CCRC_NUM_ACC; k++)
		begin
			mreg[CCRC_ACC_VMAX_OFS[k]] = CCRC_ACC_VMAX_RST[k];
			mreg[CCRC_ACC_VMIN_OFS[k]] = CCRC_ACC_VMIN_RST[k];
			mreg[CCRC_ACC_CODE_OFS[k]] = {6'h00, CCRC_ACC_CODE_RST[k]};
		end
		mreg[CCRC_SB_CTRL_OFS] = {5'h00, CCRC_SB_CTRL_RST};
		mreg[CCRC_MOIST_VTH_OFS] = CCRC_MOIST_VTH_RST;
		mreg[CCRC_MOIST_CTRL_OFS] = {3'h0, CCRC_MOIST_CTRL_RST};
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		for (int a = 8'h2F; a < 8'h55; a++) rd(8'(a));
		chk_moist();
		for (int a = 8'h2F; a < 8'h55; a++) wr(8'(a), 8'hFF);
		for (int a = 8'h2F; a < 8'h55; a++) rd(8'(a));
		chk_moist();
		for (int c = 0; c < 4; c++)
		begin
			wr(CCRC_MOIST_VTH_OFS, rnd());
			wr(CCRC_MOIST_PU_OFS, rnd());
			wr(CCRC_MOIST_PD_OFS, rnd());
			wr(CCRC_MOIST_CTRL_OFS, 8'(c));
			chk_moist();
			wr(CCRC_MOIST_CTRL_OFS, 8'(c) | 8'h10);
			chk_moist();
		end
		// periodic launches only while unattached
		wr(CCRC_MOIST_CTRL_OFS, 8'h1A);
		base = mo_starts;
		unattached = 1'b1;
		repeat (PER - 10) @(negedge sys_clk);
		chk_cnt(mo_starts, base, "early moisture launch");
		wait_until(1'b1, base + 1, 40);
		repeat (20) @(negedge sys_clk);
		chk_moist();
		wait_until(1'b1, base + 2, PER + 40);
		repeat (20) @(negedge sys_clk);
		chk_moist();
		unattached = 1'b0;
		base = mo_starts;
		repeat (3 * PER) @(negedge sys_clk);
		chk_cnt(mo_starts, base, "attached moisture launch");
		// manual request held while attached, then cancelled once
		wr(CCRC_MOIST_CTRL_OFS, 8'h16);
		repeat (PER) @(negedge sys_clk);
		chk_cnt(mo_starts, base, "pending manual");
		rd(CCRC_MOIST_CTRL_OFS);
		unattached = 1'b1;
		wait_until(1'b1, base + 1, 10);
		repeat (20) @(negedge sys_clk);
		rd(CCRC_MOIST_CTRL_OFS);
		unattached = 1'b0;
		wr(CCRC_MOIST_CTRL_OFS, 8'h16);
		wr(CCRC_MOIST_CTRL_OFS, 8'h12);
		unattached = 1'b1;
		repeat (PER) @(negedge sys_clk);
		chk_cnt(mo_starts, base + 1, "cancelled manual");
		unattached = 1'b0;
		// sideband: manual blocked, manual allowed, single shot
		for (int m = 0; m < 2; m++)
		begin
			wr(CCRC_SB_CTRL_OFS, 8'(m));
			base = sb_starts;
			sideband_manual_request = 1'b1;
			@(negedge sys_clk);
			sideband_manual_request = 1'b0;
			repeat (30) @(negedge sys_clk);
			chk_cnt(sb_starts, base + m, "manual sideband");
		end
		wr(CCRC_SB_CTRL_OFS, 8'h02);
		base = sb_starts;
		debug_acc_sink = 1'b1;
		repeat (100) @(negedge sys_clk);
		chk_cnt(sb_starts, base + 1, "single shot");
		debug_acc_sink = 1'b0;
		// continuous run over random class windows, two classes identical
		for (int k = 0; k < CCRC_NUM_ACC; k++)
		begin
			v1 = rnd();
			v2 = rnd();
			wr(CCRC_ACC_VMIN_OFS[k], (v1 < v2) ? v1 : v2);
			wr(CCRC_ACC_VMAX_OFS[k], (v1 < v2) ? v2 : v1);
			wr(CCRC_ACC_CODE_OFS[k], rnd());
		end
		wr(CCRC_ACC_VMIN_OFS[4], mreg[CCRC_ACC_VMIN_OFS[0]]);
		wr(CCRC_ACC_VMAX_OFS[4], mreg[CCRC_ACC_VMAX_OFS[0]]);
		wr(CCRC_ACC_CODE_OFS[4], mreg[CCRC_ACC_CODE_OFS[0]]);
		wr(CCRC_SB_CTRL_OFS, 8'h04);
		base = sb_starts;
		debug_acc_sink = 1'b1;
		for (int i = 1; i <= 60; i++)
		begin
			wait_until(1'b0, base + i, 40);
			r = rnd();
			lat <= r[3:0];
			pay1 <= mk_pay();
			pay2 <= mk_pay();
		end
		debug_acc_sink = 1'b0;
		repeat (40) @(negedge sys_clk);
		base = sb_starts;
		repeat (100) @(negedge sys_clk);
		chk_cnt(sb_starts, base, "continuous after sink drop");
		wrap_up();
	end
endmodule : ccrc_top_tb
`default_nettype wire
